// file: rtl/brownout_fault_sequencer.v
// fault sequencer: line-low detection, fault gathering, ready and gate control
//
// Summary of operation
// [R1] line below threshold closes the clamp switch holding the pin near 980 mV
// [R2] first comparator high sets the event latch and starts 500 ms blanking
// [R3] no line-low fault is declared while blanking runs
// [R4] blanking expiry starts a 50 ms detection window timer
// [R5] comparator high at expiry or inside the window asserts line-low fault
// [R6] comparator low for the whole window means no fault
// [R7] window end clears event latch and both timers
// [R8] line-low fault disables gates, grounds control node, holds ready low
// [R9] line-low fault also resets timers, opens clamp, enables hysteresis sink
// [R10] before supply turn-on the pin is held low so start is in fault
// [R11] after turn-on sink stays enabled until pin rises above threshold
// [R12] over-temperature trip disables gates until temperature falls below lower limit
// [R13] supply reset selects the upper thermal trip threshold
// [R14] lockout releases above turn-on level, re-engages below off level
// [R15] lockout or circuit off keeps both gate outputs sinking
// [R16] timing current low beyond 30 us sets open-pin latch, circuit off
// [R17] open-pin latch clears only during supply lockout
// [R18] any fault turns circuit off; recovery is automatic once all clear
// [R19] ready is high only during nominal regulated operation
// [R20] start-up latch holds ready low until error amplifier stops charging
// [R21] timers run from a prescaled tick; comparator inputs pass two flops
// [R22] supply lockout resets latch, timers, start-up latch, leaving fault set
`timescale 1ns/1ps
`default_nettype none
`include "fault_seq_defines.vh"
module brownout_fault_sequencer #(
    parameter [`MS_CNT_W-1:0] US_PER_MS   = `US_PER_MS,
    parameter [`MS_CNT_W-1:0] BLANK_MS    = `BLANK_TIME_MS,
    parameter [`MS_CNT_W-1:0] WINDOW_MS   = `WINDOW_TIME_MS
) (
    input  wire clk,
    input  wire rst_n,
    input  wire lineLowCmpOut,
    input  wire outputUndervoltProt,
    input  wire externalLatchOff,
    input  wire overTemperatureTrip,
    input  wire timingCurrentLow,
    input  wire errAmpCharging,
    input  wire supplyAboveOn,
    input  wire supplyBelowOff,
    output reg  gateEnableA_ff,
    output reg  gateEnableB_ff,
    output reg  controlNodeGround_ff,
    output reg  readyToDownstream_ff,
    output reg  lineClampSwitch_ff,
    output reg  hysteresisSinkEnable_ff,
    output reg  lineLowPinHold_ff,
    output reg  thermalUpperSel_ff,
    output reg  lineLowFaultState_ff,
    output reg  lineLowEventLatch_ff,
    output reg  openTimingFault_ff,
    output reg  supplyLockout_ff,
    output reg  startupLatch_ff
);
    // one-hot states of the line-low sequencer
    localparam [3:0] ST_IDLE   = 4'h1;
    localparam [3:0] ST_BLANK  = 4'h2;
    localparam [3:0] ST_WINDOW = 4'h4;
    localparam [3:0] ST_FAULT  = 4'h8;

    // synchroniser input and output vectors
    wire [`SYNC_W-1:0]     rawIn;
    wire [`SYNC_W-1:0]     syncIn;

    // synchronised comparator decisions
    wire                   lineLow;
    wire                   underVolt;
    wire                   latchOff;
    wire                   overTemp;
    wire                   timingLow;
    wire                   errAmpChg;
    wire                   aboveOn;
    wire                   belowOff;

    // gathered shutdown request and timer expiries
    wire                   circuitOff;
    wire                   blankExpire;
    wire                   windowExpire;

    // prescaler counters and ticks
    reg  [`US_CNT_W-1:0]   usCnt_ff;
    reg                    usTick_ff;
    reg  [`MS_CNT_W-1:0]   msCnt_ff;
    reg                    msTick_ff;

    // line-low sequencer state, timers and next values
    reg  [3:0]             state_ff;
    reg  [3:0]             nxt_state;
    reg  [`MS_CNT_W-1:0]   blankCnt_ff;
    reg  [`MS_CNT_W-1:0]   nxt_blankCnt;
    reg  [`MS_CNT_W-1:0]   winCnt_ff;
    reg  [`MS_CNT_W-1:0]   nxt_winCnt;
    reg                    nxt_eventLatch;

    // open pin counter and thermal shutdown flag
    reg  [`OPEN_CNT_W-1:0] openCnt_ff;
    reg                    thermalShut_ff;

    // comparator decisions arrive asynchronously [R21]
    assign rawIn = {supplyBelowOff, supplyAboveOn, errAmpCharging, timingCurrentLow,
                    overTemperatureTrip, externalLatchOff, outputUndervoltProt,
                    lineLowCmpOut};

    sync_2ff #(
        .WIDTH(`SYNC_W)
    ) u_sync (
        .clk    (clk),
        .rst_n  (rst_n),
        .asyncIn(rawIn),
        .syncOut(syncIn)
    );

    assign lineLow   = syncIn[`IN_LINE_LOW];
    assign underVolt = syncIn[`IN_UNDERVOLT];
    assign latchOff  = syncIn[`IN_LATCH_OFF];
    assign overTemp  = syncIn[`IN_OVER_TEMP];
    assign timingLow = syncIn[`IN_TIMING_LOW];
    assign errAmpChg = syncIn[`IN_ERRAMP_CHARGE];
    assign aboveOn   = syncIn[`IN_SUPPLY_ABOVE_ON];
    assign belowOff  = syncIn[`IN_SUPPLY_BELOW_OFF];

    // gathered shutdown causes [R18]
    assign circuitOff = lineLowFaultState_ff | underVolt | latchOff | thermalShut_ff |
                        openTimingFault_ff | supplyLockout_ff;

    // timer expiries on the ms tick that completes each count [R4] [R7]
    assign blankExpire  = msTick_ff &&
                          (blankCnt_ff + {{(`MS_CNT_W-1){1'b0}}, 1'b1} >= BLANK_MS);
    assign windowExpire = msTick_ff &&
                          (winCnt_ff + {{(`MS_CNT_W-1){1'b0}}, 1'b1} >= WINDOW_MS);

    // microsecond and millisecond prescaler ticks [R21]
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            usCnt_ff  <= {`US_CNT_W{1'b0}};
            usTick_ff <= 1'b0;
            msCnt_ff  <= {`MS_CNT_W{1'b0}};
            msTick_ff <= 1'b0;
        end else begin
            usTick_ff <= (usCnt_ff == `US_CNT_LAST);
            msTick_ff <= 1'b0;
            if (usCnt_ff == `US_CNT_LAST) begin
                usCnt_ff <= {`US_CNT_W{1'b0}};
            end else begin
                usCnt_ff <= usCnt_ff + {{(`US_CNT_W-1){1'b0}}, 1'b1};
            end
            if (usTick_ff) begin
                if (msCnt_ff >= US_PER_MS - {{(`MS_CNT_W-1){1'b0}}, 1'b1}) begin
                    msCnt_ff  <= {`MS_CNT_W{1'b0}};
                    msTick_ff <= 1'b1;
                end else begin
                    msCnt_ff <= msCnt_ff + {{(`MS_CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // supply lockout with hysteresis between on and off levels [R14]
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            supplyLockout_ff <= 1'b1;
        end else if (belowOff) begin
            supplyLockout_ff <= 1'b1; // re-engage below off level [R14]
        end else if (aboveOn) begin
            supplyLockout_ff <= 1'b0; // release above turn-on level [R14]
        end
    end

    // line-low sequencer next state
    always @* begin
        nxt_state      = state_ff;
        nxt_blankCnt   = blankCnt_ff;
        nxt_winCnt     = winCnt_ff;
        nxt_eventLatch = lineLowEventLatch_ff;
        case (state_ff)
            ST_IDLE: begin
                // timers rest at zero between events
                nxt_blankCnt = {`MS_CNT_W{1'b0}};
                nxt_winCnt   = {`MS_CNT_W{1'b0}};
                if (lineLow) begin
                    nxt_eventLatch = 1'b1; // first high sets the latch [R2]
                    nxt_state      = ST_BLANK; // start blanking [R2]
                end
            end

            ST_BLANK: begin
                // no fault can be declared here before blanking expires [R3]
                if (msTick_ff) begin
                    nxt_blankCnt = blankCnt_ff + {{(`MS_CNT_W-1){1'b0}}, 1'b1};
                end
                if (blankExpire) begin
                    if (lineLow) begin
                        nxt_state = ST_FAULT; // high at expiry [R5]
                    end else begin
                        nxt_state  = ST_WINDOW; // open detection window [R4]
                        nxt_winCnt = {`MS_CNT_W{1'b0}};
                    end
                end
            end

            ST_WINDOW: begin
                if (msTick_ff) begin
                    nxt_winCnt = winCnt_ff + {{(`MS_CNT_W-1){1'b0}}, 1'b1};
                end
                if (lineLow) begin
                    nxt_state = ST_FAULT; // high inside the window [R5]
                end else if (windowExpire) begin
                    nxt_state      = ST_IDLE; // stayed low, no fault [R6]
                    nxt_eventLatch = 1'b0; // window end clears latch [R7]
                    nxt_blankCnt   = {`MS_CNT_W{1'b0}}; // [R7]
                    nxt_winCnt     = {`MS_CNT_W{1'b0}}; // [R7]
                end
            end

            ST_FAULT: begin
                nxt_blankCnt   = {`MS_CNT_W{1'b0}}; // timers held reset [R9]
                nxt_winCnt     = {`MS_CNT_W{1'b0}}; // [R9]
                nxt_eventLatch = 1'b0;
                // leave only with the pin back up and the supply released
                if (!lineLow && !supplyLockout_ff) begin
                    nxt_state = ST_IDLE; // pin back above threshold
                end
            end

            default: begin
                // an illegal code falls back into the fault state
                nxt_state      = ST_FAULT;
                nxt_blankCnt   = {`MS_CNT_W{1'b0}};
                nxt_winCnt     = {`MS_CNT_W{1'b0}};
                nxt_eventLatch = 1'b0;
            end
        endcase

        // lockout forces the fault and clears latch and timers [R22]
        if (supplyLockout_ff) begin
            nxt_state      = ST_FAULT;
            nxt_blankCnt   = {`MS_CNT_W{1'b0}};
            nxt_winCnt     = {`MS_CNT_W{1'b0}};
            nxt_eventLatch = 1'b0;
        end
    end

    // line-low sequencer registers, reset into fault [R10] [R22]
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff             <= ST_FAULT;
            blankCnt_ff          <= {`MS_CNT_W{1'b0}};
            winCnt_ff            <= {`MS_CNT_W{1'b0}};
            lineLowEventLatch_ff <= 1'b0;
            lineLowFaultState_ff <= 1'b1;
        end else begin
            state_ff             <= nxt_state;
            blankCnt_ff          <= nxt_blankCnt;
            winCnt_ff            <= nxt_winCnt;
            lineLowEventLatch_ff <= nxt_eventLatch;
            lineLowFaultState_ff <= (nxt_state == ST_FAULT); // [R5]
        end
    end

    // clamp, hysteresis sink and pin hold-down
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lineClampSwitch_ff      <= 1'b0;
            hysteresisSinkEnable_ff <= 1'b0;
            lineLowPinHold_ff       <= 1'b1;
        end else begin
            // clamp closed while line low and no fault [R1] [R9]
            lineClampSwitch_ff <= lineLow && (nxt_state != ST_FAULT);
            // sink on in fault after turn-on until pin rises [R9] [R11]
            hysteresisSinkEnable_ff <= (nxt_state == ST_FAULT) && !supplyLockout_ff &&
                                       lineLow;
            // pin pulled below threshold until turn-on level [R10]
            lineLowPinHold_ff <= supplyLockout_ff;
        end
    end

    // thermal shutdown with threshold selection
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            thermalShut_ff     <= 1'b0;
            thermalUpperSel_ff <= 1'b1; // supply reset picks upper limit [R13]
        end else if (thermalUpperSel_ff) begin
            if (overTemp) begin
                thermalShut_ff     <= 1'b1; // trip at upper limit [R12]
                thermalUpperSel_ff <= 1'b0;
            end
        end else if (!overTemp) begin
            thermalShut_ff     <= 1'b0; // cooled below lower limit [R12]
            thermalUpperSel_ff <= 1'b1;
        end
    end

    // open timing pin blanking and fault latch
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            openCnt_ff         <= {`OPEN_CNT_W{1'b0}};
            openTimingFault_ff <= 1'b0;
        end else begin
            if (!timingLow) begin
                openCnt_ff <= {`OPEN_CNT_W{1'b0}};
            end else if (usTick_ff && (openCnt_ff != `OPEN_CNT_LIMIT)) begin
                openCnt_ff <= openCnt_ff + {{(`OPEN_CNT_W-1){1'b0}}, 1'b1};
            end
            if (supplyLockout_ff) begin
                openTimingFault_ff <= 1'b0; // cleared only in lockout [R17]
            end else if (timingLow && (openCnt_ff == `OPEN_CNT_LIMIT)) begin
                openTimingFault_ff <= 1'b1; // persisted beyond blanking [R16]
            end
        end
    end

    // start-up latch: set while off, cleared when regulation is reached
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            startupLatch_ff <= 1'b1;
        end else if (circuitOff) begin
            startupLatch_ff <= 1'b1; // start or recovery from fault [R20] [R22]
        end else if (!errAmpChg) begin
            startupLatch_ff <= 1'b0; // error amplifier stopped charging [R20]
        end
    end

    // gate drive, control node and ready output
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gateEnableA_ff       <= 1'b0;
            gateEnableB_ff       <= 1'b0;
            controlNodeGround_ff <= 1'b1;
            readyToDownstream_ff <= 1'b0;
        end else begin
            // gates sink whenever off, resume automatically [R8] [R12] [R15] [R18]
            gateEnableA_ff       <= !circuitOff;
            gateEnableB_ff       <= !circuitOff;
            controlNodeGround_ff <= circuitOff; // soft-start on recovery [R8]
            // ready only in nominal regulated operation [R8] [R19] [R20]
            readyToDownstream_ff <= !circuitOff && !startupLatch_ff;
        end
    end
endmodule
`default_nettype wire

// file: rtl/fault_seq_defines.vh
// constants shared by the fault sequencer files
`ifndef FAULT_SEQ_DEFINES_VH
`define FAULT_SEQ_DEFINES_VH

// clock rate and prescaler
`define CLK_RATE_MHZ        125
`define US_CYCLES           (`CLK_RATE_MHZ * 1)
`define US_CNT_W            7
`define US_CNT_LAST         7'h7C

// line-low blanking and detection window, in ms
`define BLANK_TIME_MS       500
`define WINDOW_TIME_MS      50
`define US_PER_MS           1000
`define MS_CNT_W            10

// open timing pin blanking, in us
`define OPEN_BLANK_US       30
`define OPEN_CNT_W          6
`define OPEN_CNT_LIMIT      6'h1E

// synchronised input vector layout
`define SYNC_W              8
`define IN_LINE_LOW         0
`define IN_UNDERVOLT        1
`define IN_LATCH_OFF        2
`define IN_OVER_TEMP        3
`define IN_TIMING_LOW       4
`define IN_ERRAMP_CHARGE    5
`define IN_SUPPLY_ABOVE_ON  6
`define IN_SUPPLY_BELOW_OFF 7

`endif

// file: rtl/sync_2ff.v
// two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
    parameter WIDTH = 8
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg stage1_ff;
            reg stage2_ff;
            // first stage feeds only the second
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    stage1_ff <= 1'b0;
                    stage2_ff <= 1'b0;
                end else begin
                    stage1_ff <= asyncIn[i];
                    stage2_ff <= stage1_ff;
                end
            end
            assign syncOut[i] = stage2_ff;
        end
    endgenerate
endmodule
`default_nettype wire

// file: testbench/fault_seq_checker.sv
// port-level assertions for the fault sequencer
`timescale 1ns/1ps
`default_nettype none
module fault_seq_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic gateEnableA_ff,
    input wire logic gateEnableB_ff,
    input wire logic controlNodeGround_ff,
    input wire logic readyToDownstream_ff,
    input wire logic lineClampSwitch_ff,
    input wire logic lineLowPinHold_ff,
    input wire logic lineLowFaultState_ff,
    input wire logic lineLowEventLatch_ff,
    input wire logic openTimingFault_ff,
    input wire logic supplyLockout_ff,
    input wire logic startupLatch_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic      [11:0] latchAge_ff;
    wire logic        gatesOff = !gateEnableA_ff && !gateEnableB_ff;
    // cycles the event latch has stayed set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            latchAge_ff <= 12'h000;
        else
            latchAge_ff <= lineLowEventLatch_ff ? latchAge_ff + 12'h001 : 12'h000;
    end
    a_ready_cause: assert property (
        readyToDownstream_ff |-> !$past(startupLatch_ff) && !$past(lineLowFaultState_ff)
        && !$past(supplyLockout_ff)) else $error("ready high without clean state");
    a_fault_outputs: assert property (
        lineLowFaultState_ff && $past(lineLowFaultState_ff) |-> gatesOff && controlNodeGround_ff
        && !readyToDownstream_ff && !lineClampSwitch_ff) else $error("fault outputs wrong");
    a_lockout_sinks: assert property (
        supplyLockout_ff && $past(supplyLockout_ff) |-> gatesOff)
        else $error("gates on during lockout");
    a_blank_holds: assert property (
        $rose(lineLowFaultState_ff) && !supplyLockout_ff && !$past(supplyLockout_ff)
        |-> latchAge_ff >= 12'h3DE) else $error("line fault inside blanking");
    a_window_ends: assert property (
        latchAge_ff <= 12'h834) else $error("event latch never cleared");
    a_latch_clamp: assert property (
        $rose(lineLowEventLatch_ff) |-> lineClampSwitch_ff) else $error("clamp not closed");
    a_open_sticky: assert property (
        $fell(openTimingFault_ff) |-> $past(supplyLockout_ff))
        else $error("open pin cleared early");
    a_open_off: assert property (
        openTimingFault_ff |=> gatesOff) else $error("gates on with open pin");
    a_lockout_state: assert property (
        supplyLockout_ff && $past(supplyLockout_ff) |-> startupLatch_ff
        && !lineLowEventLatch_ff && lineLowFaultState_ff) else $error("lockout state wrong");
    a_pin_hold: assert property (
        lineLowPinHold_ff == $past(supplyLockout_ff)) else $error("pin hold mismatch");
    // main scenarios reached
    cover property ($rose(lineLowFaultState_ff));
    cover property ($fell(lineLowEventLatch_ff) && !lineLowFaultState_ff);
    cover property ($rose(openTimingFault_ff));
endmodule
bind brownout_fault_sequencer fault_seq_checker chk_u (
    .clk, .rst_n, .gateEnableA_ff, .gateEnableB_ff, .controlNodeGround_ff,
    .readyToDownstream_ff, .lineClampSwitch_ff, .lineLowPinHold_ff, .lineLowFaultState_ff,
    .lineLowEventLatch_ff, .openTimingFault_ff, .supplyLockout_ff, .startupLatch_ff
);
`default_nettype wire

// file: testbench/analog_side_model.sv
// comparators and error amplifier around the sequencer
`timescale 1ns/1ps
`default_nettype none
module analog_side_model #(
    parameter CHARGE_CYCLES = 50
) (
    input  wire logic clk,
    input  wire logic vccUp,
    input  wire logic vccMid,
    input  wire logic lineOk,
    input  wire logic pinHold,
    input  wire logic gateOn,
    output wire logic lineLowCmp,
    output wire logic aboveOn,
    output wire logic belowOff,
    output wire logic charging
);
    int chargeCnt = 0;
    // supply comparator pair, both false while supply sits between levels
    assign aboveOn  = vccUp && !vccMid;
    assign belowOff = !vccUp && !vccMid;
    // pin pulled below threshold while held reads as line low
    assign lineLowCmp = pinHold || !lineOk;
    // amplifier charges for a while after each gate start
    always @(posedge clk) begin
        if (!gateOn)
            chargeCnt <= 0;
        else if (chargeCnt < CHARGE_CYCLES)
            chargeCnt <= chargeCnt + 1;
    end
    assign charging = (chargeCnt < CHARGE_CYCLES);
endmodule
`default_nettype wire

// file: testbench/brownout_fault_sequencer_tb.sv
// directed testbench for the fault sequencer
`timescale 1ns/1ps
`default_nettype none
module brownout_fault_sequencer_tb;
    logic       clk = 1'b0;
    logic       rst_n, vccUp, vccMid, lineOk, timingLow;
    logic [2:0] faultIn;
    wire logic  lineLowCmp, aboveOn, belowOff, charging, gateA, gateB, ctlGround, ready;
    wire logic  clamp, sink, pinHold, upperSel, lineFault, eventLatch, openFault, lockout;
    int         miscompares = 0;
    int         checkCount = 0;

    brownout_fault_sequencer #(.US_PER_MS(10'h002), .BLANK_MS(10'h005), .WINDOW_MS(10'h003))
    dut_u (
        .clk(clk), .rst_n(rst_n), .lineLowCmpOut(lineLowCmp), .outputUndervoltProt(faultIn[0]),
        .externalLatchOff(faultIn[1]), .overTemperatureTrip(faultIn[2]),
        .timingCurrentLow(timingLow), .errAmpCharging(charging), .supplyAboveOn(aboveOn),
        .supplyBelowOff(belowOff), .gateEnableA_ff(gateA), .gateEnableB_ff(gateB),
        .controlNodeGround_ff(ctlGround), .readyToDownstream_ff(ready),
        .lineClampSwitch_ff(clamp), .hysteresisSinkEnable_ff(sink), .lineLowPinHold_ff(pinHold),
        .thermalUpperSel_ff(upperSel), .lineLowFaultState_ff(lineFault),
        .lineLowEventLatch_ff(eventLatch), .openTimingFault_ff(openFault),
        .supplyLockout_ff(lockout), .startupLatch_ff());

    analog_side_model model_u (
        .clk(clk), .vccUp(vccUp), .vccMid(vccMid), .lineOk(lineOk), .pinHold(pinHold),
        .gateOn(gateA && gateB), .lineLowCmp(lineLowCmp), .aboveOn(aboveOn),
        .belowOff(belowOff), .charging(charging));

    task automatic chk(input logic got, input logic exp);
        checkCount++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic waitReady();
        repeat (400) if (ready !== 1'b1) @(negedge clk);
    endtask

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // watchdog well beyond the expected run
    initial begin
        cyc(60000);
        miscompares++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        vccUp = 1'b0;
        vccMid = 1'b0;
        lineOk = 1'b0;
        timingLow = 1'b0;
        faultIn = 3'h0;
        cyc(5);
        rst_n = 1'b1;
        chk(upperSel, 1'b1);
        chk(lineFault, 1'b1);
        cyc(20);
        chk(lockout, 1'b1);
        chk(gateA, 1'b0);
        // turn-on with the line still low
        vccUp = 1'b1;
        cyc(10);
        chk(lockout, 1'b0);
        chk(sink, 1'b1);
        chk(lineFault, 1'b1);
        lineOk = 1'b1;
        cyc(10);
        chk(sink, 1'b0);
        chk(ready, 1'b0);
        waitReady();
        chk(ready, 1'b1);
        chk(gateB, 1'b1);
        chk(ctlGround, 1'b0);
        // short dropout is blanked
        lineOk = 1'b0;
        cyc(10);
        chk(eventLatch, 1'b1);
        chk(clamp, 1'b1);
        cyc(590);
        chk(ready, 1'b1);
        lineOk = 1'b1;
        repeat (2200) if (eventLatch !== 1'b0) @(negedge clk);
        chk(eventLatch, 1'b0);
        chk(lineFault, 1'b0);
        // line still low at blanking expiry
        lineOk = 1'b0;
        cyc(900);
        chk(lineFault, 1'b0);
        repeat (600) if (lineFault !== 1'b1) @(negedge clk);
        chk(lineFault, 1'b1);
        cyc(3);
        chk(gateA, 1'b0);
        chk(ready, 1'b0);
        chk(ctlGround, 1'b1);
        chk(clamp, 1'b0);
        chk(sink, 1'b1);
        chk(eventLatch, 1'b0);
        lineOk = 1'b1;
        waitReady();
        chk(ready, 1'b1);
        // line low again inside the detection window
        lineOk = 1'b0;
        cyc(20);
        lineOk = 1'b1;
        cyc(1400);
        chk(lineFault, 1'b0);
        chk(eventLatch, 1'b1);
        lineOk = 1'b0;
        cyc(12);
        chk(lineFault, 1'b1);
        lineOk = 1'b1;
        waitReady();
        chk(ready, 1'b1);
        // other shutdown causes, each recovering by itself
        for (int i = 0; i < 3; i++) begin
            faultIn = 3'(1 << i);
            cyc(8);
            chk(ready, 1'b0);
            chk(gateA, 1'b0);
            chk(upperSel, 1'(i != 2));
            faultIn = 3'h0;
            waitReady();
            chk(ready, 1'b1);
            chk(upperSel, 1'b1);
        end
        // open timing pin: short glitch ignored, long one latched
        timingLow = 1'b1;
        cyc(2000);
        timingLow = 1'b0;
        cyc(10);
        chk(openFault, 1'b0);
        timingLow = 1'b1;
        cyc(4000);
        chk(openFault, 1'b1);
        timingLow = 1'b0;
        cyc(20);
        chk(openFault, 1'b1);
        chk(gateA, 1'b0);
        // supply inside the hysteresis band keeps lockout released
        vccMid = 1'b1;
        vccUp = 1'b0;
        cyc(10);
        chk(lockout, 1'b0);
        chk(openFault, 1'b1);
        vccMid = 1'b0;
        cyc(10);
        chk(lockout, 1'b1);
        chk(openFault, 1'b0);
        chk(gateB, 1'b0);
        // rising into the band keeps lockout engaged
        vccMid = 1'b1;
        vccUp = 1'b1;
        cyc(10);
        chk(lockout, 1'b1);
        vccMid = 1'b0;
        waitReady();
        chk(ready, 1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
